// >>> hdl/wake_reset_pkg.sv
// Shared constants and types for the reset, watchdog and wake-up block.
// Assumes a 200 MHz core clock; long counts are top-level parameters.
package wake_reset_pkg;

    // Core clock rate
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;

    // Times in their printed units
    localparam int unsigned RST_HOLD_US = 3400; // reset_hold_time
    localparam int unsigned NREQ_MS = 350; // Normal Request window
    localparam int unsigned WD_MS = 350; // Watchdog period
    localparam int unsigned FWAKE_MS = 100; // Timed wake delay
    localparam int unsigned CYC_PERIOD_MS = 20; // Cyclic sense period
    localparam int unsigned CYC_ON_US = 50; // Switch on-time per cycle
    localparam int unsigned IRQ_US = 10; // Host interrupt pulse

    // Interrupt pulse length in cycles
    localparam int unsigned IRQ_CYC = IRQ_US * CLK_MHZ;
    localparam int unsigned IRQ_W = 12;
    localparam int unsigned CNT_W = 27;

    // Register addresses of the write port
    localparam logic [2:0] ADDR_MODE = 3'h0; // mode_control_reg
    localparam logic [2:0] ADDR_BUS = 3'h2;
    localparam logic [2:0] ADDR_WAKE = 3'h4; // wake_input_reg
    localparam logic [2:0] ADDR_TIM = 3'h5;
    localparam logic [2:0] ADDR_LP = 3'h6; // low_power_ctrl_reg

    // Field positions
    localparam int unsigned MODE_SAFE_BIT = 3;
    localparam int unsigned WAKE_SENS01_BIT = 0;
    localparam int unsigned WAKE_SENS23_BIT = 1;
    localparam int unsigned BUS_WAKE_BIT = 0;
    localparam int unsigned LP_AUTO_BIT = 0;
    localparam int unsigned LP_TIMED_BIT = 1;
    localparam int unsigned LP_WDSTOP_BIT = 2;
    localparam int unsigned LP_LINK_BIT = 3;

    // Mode commands in the low three bits of mode_control_reg
    localparam logic [2:0] CMD_NORMAL = 3'h1;
    localparam logic [2:0] CMD_STANDBY = 3'h2;
    localparam logic [2:0] CMD_SLEEP = 3'h3;
    localparam logic [2:0] CMD_STOP = 3'h4;

    // Operating states
    typedef enum logic [2:0] {
        st_reset = 3'b000,
        st_nreq = 3'b001,
        st_normal = 3'b010,
        st_standby = 3'b011,
        st_sleep = 3'b100,
        st_stop = 3'b101
    } state_t;

    // One register write from the link
    typedef struct packed {
        logic [2:0] addr;
        logic [3:0] data;
    } spi_write_t;

    // Stored configuration
    typedef struct packed {
        logic safe;
        logic [1:0] sens;
        logic bus_wake;
        logic inputs_to_switch_link;
        logic switch_auto_cycle;
        logic timed_wake_enable;
        logic wd_stop;
    } cfg_t;

    // Latched wake-up sources
    typedef struct packed {
        logic [3:0] inputs;
        logic bus;
    } wake_src_t;

endpackage

// >>> hdl/sbc_reset_watchdog_wakeup.sv
// Reset, watchdog fault and wake-up control of a supply supervisor.
// Register writes arrive on the link clock; pins are asynchronous.
// Behaviour
// - Two policies by safe bit, default 0
// - Policy unaffected by operating state changes
// - Reset asserted at power-up and sleep wake
// - Policy 1: reset on undervoltage or timeout
// - Fault output falls with reset, held
// - Policy 2: timeout leaves reset high
// - Stop: reset only on enabled watchdog, undervoltage
// - Latch wake source for host reading
// - Sleep wake powers regulator, stop interrupts
// - Current wake input levels readable
// - Level sensitivity set per input pair
// - Cyclic sense pulses switch, wakes on change
// - Wake mode common to all inputs
// - Cyclic sense and timed wake exclusive
// - Timed wake after programmed delay
// - Bus wake only when enabled
// - Chip-select rising edge wakes device
// - Power-up, sleep wake pass through reset
// - Unconfigured device resets every window
// - Reset held for hold time, then request
// - Request window expiry: reset or sleep
`timescale 1ns/1ps
module sbc_reset_watchdog_wakeup #(
    parameter int unsigned RST_HOLD_CYC =
        wake_reset_pkg::RST_HOLD_US * wake_reset_pkg::CLK_MHZ,
    parameter int unsigned NREQ_CYC =
        wake_reset_pkg::NREQ_MS * wake_reset_pkg::CYC_PER_MS,
    parameter int unsigned WD_CYC =
        wake_reset_pkg::WD_MS * wake_reset_pkg::CYC_PER_MS,
    parameter int unsigned FWAKE_CYC =
        wake_reset_pkg::FWAKE_MS * wake_reset_pkg::CYC_PER_MS,
    parameter int unsigned CYC_PERIOD_CYC =
        wake_reset_pkg::CYC_PERIOD_MS * wake_reset_pkg::CYC_PER_MS,
    parameter int unsigned CYC_ON_CYC =
        wake_reset_pkg::CYC_ON_US * wake_reset_pkg::CLK_MHZ
) (
    // Clocks and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic link_clk,
    // Register writes, link clock domain
    input wire logic link_wr,
    input wire wake_reset_pkg::spi_write_t link_data,
    output logic link_busy,
    // Asynchronous pins
    input wire logic main_reg_low,
    input wire logic bus_activity,
    input wire logic chip_select_n,
    input wire logic [3:0] wake_inputs,
    // Debug state, core clock domain
    input wire logic debug_mode,
    // Pin outputs
    output logic reset_out_n,
    output logic watchdog_fault_out_n,
    output logic main_regulator_on,
    output logic high_side_supply_switch,
    output logic host_irq,
    // Status
    output wake_reset_pkg::wake_src_t wake_src,
    output logic [3:0] wake_inputs_state,
    output wake_reset_pkg::cfg_t cfg_state,
    output wake_reset_pkg::state_t sbc_state
);

    localparam int unsigned CW = wake_reset_pkg::CNT_W;

    // True when a counter sits on its last cycle
    function automatic logic at_end(input logic [CW-1:0] c, input int unsigned lim);
        at_end = (c == CW'(lim - 1));
    endfunction

    // Per-pair level match for direct wake
    function automatic logic [3:0] level_hit(input logic [3:0] lx, input logic [1:0] sens);
        level_hit = {lx[3:2] ~^ {2{sens[wake_reset_pkg::WAKE_SENS23_BIT]}},
                     lx[1:0] ~^ {2{sens[wake_reset_pkg::WAKE_SENS01_BIT]}}};
    endfunction

    // Link side: holding word and request toggle
    wake_reset_pkg::spi_write_t hold_q, hold_d;
    logic req_q, req_d;
    logic ack_l1_q, ack_l2_q; // Ack toggle synchroniser

    // Core side synchronisers
    logic req_m1_q, req_m2_q;
    logic low1_q, low_s;
    logic bus1_q, bus_s;
    logic cs1_q, cs_s, cs_prev_q;
    logic [3:0] lx1_q, lx_s;

    // Core state
    wake_reset_pkg::state_t state_q, state_d;
    wake_reset_pkg::cfg_t cfg_q, cfg_d;
    wake_reset_pkg::wake_src_t flags_q, flags_d;
    logic [CW-1:0] tmr_q, tmr_d; // State timer
    logic [CW-1:0] wd_tmr_q, wd_tmr_d; // Watchdog timer
    logic [CW-1:0] cyc_tmr_q, cyc_tmr_d; // Cyclic sense timer
    logic [3:0] samp_q, samp_d; // Last sensed input levels
    logic [wake_reset_pkg::IRQ_W-1:0] irq_cnt_q, irq_cnt_d;
    logic ack_q, ack_d;
    logic from_sleep_q, from_sleep_d;
    logic wd_fault_q, wd_fault_d;
    logic rst_n_q, reg_on_q, hss_q, irq_q;

    // Decoded helpers
    logic wr_new, wr_mode, wr_tim, wr_wake, wr_bus, wr_lp;
    logic low_pwr, wd_run, wd_exp;
    logic cyclic_on, direct_on, cyc_sample;
    logic [3:0] in_hit;
    logic bus_hit, cs_hit, timed_hit, wake_any;
    logic [3:0] lp_data;

    // Busy until the core acknowledges the last write
    assign link_busy = req_q ^ ack_l2_q;

    // Link write capture; data stands still while busy
    always_comb
    begin
        hold_d = hold_q;
        req_d = req_q;
        if (link_wr && !link_busy)
        begin
            hold_d = link_data;
            req_d = ~req_q;
        end
    end

    // Link clock registers
    always_ff @(posedge link_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_q <= '0;
            req_q <= 1'h0;
            ack_l1_q <= 1'h0;
            ack_l2_q <= 1'h0;
        end
        else
        begin
            hold_q <= hold_d;
            req_q <= req_d;
            ack_l1_q <= ack_q;
            ack_l2_q <= ack_l1_q;
        end
    end

    // Two-stage synchronisers for every foreign input
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_m1_q <= 1'h0;
            req_m2_q <= 1'h0;
            low1_q <= 1'h0;
            low_s <= 1'h0;
            bus1_q <= 1'h0;
            bus_s <= 1'h0;
            cs1_q <= 1'h1;
            cs_s <= 1'h1;
            cs_prev_q <= 1'h1;
            lx1_q <= '0;
            lx_s <= '0;
        end
        else
        begin
            req_m1_q <= req_q;
            req_m2_q <= req_m1_q;
            low1_q <= main_reg_low;
            low_s <= low1_q;
            bus1_q <= bus_activity;
            bus_s <= bus1_q;
            cs1_q <= chip_select_n;
            cs_s <= cs1_q;
            cs_prev_q <= cs_s;
            lx1_q <= wake_inputs;
            lx_s <= lx1_q;
        end
    end

    // Write decode; hold_q is stable once the toggle is seen
    assign wr_new = req_m2_q ^ ack_q;
    assign wr_mode = wr_new && (hold_q.addr == wake_reset_pkg::ADDR_MODE);
    assign wr_tim = wr_new && (hold_q.addr == wake_reset_pkg::ADDR_TIM);
    assign wr_wake = wr_new && (hold_q.addr == wake_reset_pkg::ADDR_WAKE);
    assign wr_bus = wr_new && (hold_q.addr == wake_reset_pkg::ADDR_BUS);
    assign wr_lp = wr_new && (hold_q.addr == wake_reset_pkg::ADDR_LP);
    assign lp_data = hold_q.data;

    // Low power states
    assign low_pwr = (state_q == wake_reset_pkg::st_sleep) ||
                     (state_q == wake_reset_pkg::st_stop);

    // Watchdog runs only where allowed, never in debug
    assign wd_run = !debug_mode && (
        (state_q == wake_reset_pkg::st_normal) ||
        (state_q == wake_reset_pkg::st_standby) ||
        ((state_q == wake_reset_pkg::st_stop) && cfg_q.wd_stop));
    assign wd_exp = wd_run && at_end(wd_tmr_q, WD_CYC);

    // One mode for all four inputs
    assign cyclic_on = cfg_q.inputs_to_switch_link && cfg_q.switch_auto_cycle &&
                       !cfg_q.timed_wake_enable;
    assign direct_on = !cfg_q.inputs_to_switch_link && !cfg_q.switch_auto_cycle;
    assign cyc_sample = cyclic_on && low_pwr && at_end(cyc_tmr_q, CYC_ON_CYC);

    // Wake sources, seen only in low power
    always_comb
    begin
        in_hit = '0;
        if (direct_on)
        begin
            in_hit = level_hit(lx_s, cfg_q.sens);
        end
        else if (cyc_sample)
        begin
            in_hit = lx_s ^ samp_q;
        end
    end
    assign bus_hit = bus_s && cfg_q.bus_wake;
    assign cs_hit = cs_s && !cs_prev_q;
    assign timed_hit = cfg_q.timed_wake_enable && at_end(tmr_q, FWAKE_CYC);
    assign wake_any = low_pwr && ((|in_hit) || bus_hit || cs_hit || timed_hit);

    // Next values of the core state
    always_comb
    begin
        state_d = state_q;
        cfg_d = cfg_q;
        flags_d = flags_q;
        tmr_d = tmr_q + CW'(1);
        wd_tmr_d = wd_tmr_q + CW'(1);
        cyc_tmr_d = cyc_tmr_q + CW'(1);
        samp_d = samp_q;
        ack_d = req_m2_q;
        from_sleep_d = from_sleep_q;
        irq_cnt_d = '0;
        if (irq_cnt_q != '0)
        begin
            irq_cnt_d = irq_cnt_q - wake_reset_pkg::IRQ_W'(1);
        end
        // Configuration writes; state changes never touch them
        if (wr_mode)
        begin
            cfg_d.safe = hold_q.data[wake_reset_pkg::MODE_SAFE_BIT];
        end
        if (wr_wake)
        begin
            cfg_d.sens = hold_q.data[1:0];
        end
        if (wr_bus)
        begin
            cfg_d.bus_wake = hold_q.data[wake_reset_pkg::BUS_WAKE_BIT];
        end
        if (wr_lp)
        begin
            cfg_d.inputs_to_switch_link = lp_data[wake_reset_pkg::LP_LINK_BIT];
            cfg_d.switch_auto_cycle = lp_data[wake_reset_pkg::LP_AUTO_BIT];
            cfg_d.wd_stop = lp_data[wake_reset_pkg::LP_WDSTOP_BIT];
            // Cyclic request wins; timed wake refused alongside it
            cfg_d.timed_wake_enable = lp_data[wake_reset_pkg::LP_TIMED_BIT] &&
                !(lp_data[wake_reset_pkg::LP_LINK_BIT] &&
                  lp_data[wake_reset_pkg::LP_AUTO_BIT]);
        end
        // Source flags: a new wake beats a clearing write
        flags_d.inputs = (wake_any ? in_hit : 4'h0) |
                         (flags_q.inputs & ~{4{wr_wake}});
        flags_d.bus = (wake_any && bus_hit) || (flags_q.bus && !wr_bus);
        // Watchdog timer restarts on every timing write
        if (wr_tim || !wd_run || wd_exp)
        begin
            wd_tmr_d = '0;
        end
        // Fault flag: set beats clear
        wd_fault_d = wd_exp || (wd_fault_q && !wr_tim);
        // Cyclic timer and input snapshot
        if (!(low_pwr && cyclic_on) || at_end(cyc_tmr_q, CYC_PERIOD_CYC))
        begin
            cyc_tmr_d = '0;
        end
        if (!low_pwr || cyc_sample)
        begin
            samp_d = lx_s;
        end
        // Operating state
        case (state_q)
            wake_reset_pkg::st_reset:
            begin
                if (low_s)
                begin
                    tmr_d = '0; // Hold until regulator is back
                end
                else if (at_end(tmr_q, RST_HOLD_CYC))
                begin
                    state_d = wake_reset_pkg::st_nreq;
                    tmr_d = '0;
                end
            end
            wake_reset_pkg::st_nreq:
            begin
                if (wr_tim)
                begin
                    state_d = wake_reset_pkg::st_normal;
                    from_sleep_d = 1'h0;
                end
                else if (at_end(tmr_q, NREQ_CYC))
                begin
                    // Unserviced window: retry or fall back asleep
                    state_d = from_sleep_q ? wake_reset_pkg::st_sleep
                                           : wake_reset_pkg::st_reset;
                    tmr_d = '0;
                end
            end
            wake_reset_pkg::st_normal, wake_reset_pkg::st_standby:
            begin
                if (wr_mode)
                begin
                    tmr_d = '0;
                    case (hold_q.data[2:0])
                        wake_reset_pkg::CMD_NORMAL: state_d = wake_reset_pkg::st_normal;
                        wake_reset_pkg::CMD_STANDBY: state_d = wake_reset_pkg::st_standby;
                        wake_reset_pkg::CMD_SLEEP: state_d = wake_reset_pkg::st_sleep;
                        wake_reset_pkg::CMD_STOP: state_d = wake_reset_pkg::st_stop;
                        default: state_d = state_q;
                    endcase
                end
            end
            wake_reset_pkg::st_sleep:
            begin
                if (wake_any)
                begin
                    state_d = wake_reset_pkg::st_reset;
                    from_sleep_d = 1'h1;
                    tmr_d = '0;
                end
            end
            wake_reset_pkg::st_stop:
            begin
                if (wake_any)
                begin
                    state_d = wake_reset_pkg::st_nreq;
                    irq_cnt_d = wake_reset_pkg::IRQ_W'(wake_reset_pkg::IRQ_CYC);
                    tmr_d = '0;
                end
            end
            default:
            begin
                state_d = wake_reset_pkg::st_reset;
                tmr_d = '0;
            end
        endcase
        // Reset causes override the above; sleep has no regulator
        if (wd_exp && !cfg_q.safe)
        begin
            state_d = wake_reset_pkg::st_reset;
            tmr_d = '0;
        end
        if (low_s && low_pwr == (state_q == wake_reset_pkg::st_stop) &&
            state_q != wake_reset_pkg::st_reset)
        begin
            state_d = wake_reset_pkg::st_reset;
            tmr_d = '0;
        end
    end

    // Core registers; reset and regulator pins follow the next state
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= wake_reset_pkg::st_reset;
            cfg_q <= '0;
            flags_q <= '0;
            tmr_q <= '0;
            wd_tmr_q <= '0;
            cyc_tmr_q <= '0;
            samp_q <= '0;
            irq_cnt_q <= '0;
            ack_q <= 1'h0;
            from_sleep_q <= 1'h0;
            wd_fault_q <= 1'h0;
            rst_n_q <= 1'h0;
            reg_on_q <= 1'h1;
            hss_q <= 1'h0;
            irq_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            flags_q <= flags_d;
            tmr_q <= tmr_d;
            wd_tmr_q <= wd_tmr_d;
            cyc_tmr_q <= cyc_tmr_d;
            samp_q <= samp_d;
            irq_cnt_q <= irq_cnt_d;
            ack_q <= ack_d;
            from_sleep_q <= from_sleep_d;
            wd_fault_q <= wd_fault_d;
            rst_n_q <= (state_d != wake_reset_pkg::st_reset) &&
                       (state_d != wake_reset_pkg::st_sleep);
            reg_on_q <= (state_d != wake_reset_pkg::st_sleep);
            hss_q <= low_pwr && cyclic_on && (cyc_tmr_d < CW'(CYC_ON_CYC));
            irq_q <= (irq_cnt_d != '0);
        end
    end

    // Outputs
    assign reset_out_n = rst_n_q;
    assign watchdog_fault_out_n = !wd_fault_q;
    assign main_regulator_on = reg_on_q;
    assign high_side_supply_switch = hss_q;
    assign host_irq = irq_q;
    assign wake_src = flags_q;
    assign wake_inputs_state = lx_s;
    assign cfg_state = cfg_q;
    assign sbc_state = state_q;

    // Checks on the core clock
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_stop_wake;
        (state_q == wake_reset_pkg::st_stop) && wake_any;
    endsequence
    sequence s_sleep_wake;
        (state_q == wake_reset_pkg::st_sleep) && wake_any;
    endsequence

    AST_POLICY_ONLY_BY_WRITE: assert property (
        !$stable(cfg_q.safe) |-> $past(wr_mode))
        else $error("Policy changed without a mode write");
    AST_WD_RESET_POLICY1: assert property (
        wd_exp && !cfg_q.safe |=> !reset_out_n && state_q == wake_reset_pkg::st_reset)
        else $error("Timeout under policy 1 gave no reset");
    AST_WD_FAULT_WITH_RESET: assert property (
        wd_exp && !cfg_q.safe |=> $fell(watchdog_fault_out_n) && $fell(reset_out_n))
        else $error("Fault output and reset not together");
    AST_WD_FAULT_HOLDS: assert property (
        !watchdog_fault_out_n && !wr_tim |=> !watchdog_fault_out_n)
        else $error("Fault output released without timing write");
    AST_SAFE_KEEPS_RESET: assert property (
        wd_exp && cfg_q.safe && !low_s |=> reset_out_n && !watchdog_fault_out_n)
        else $error("Policy 2 timeout misbehaved");
    AST_STOP_WAKE_IRQ: assert property (
        s_stop_wake |=> state_q == wake_reset_pkg::st_nreq ##0 host_irq [*8])
        else $error("Stop wake gave no interrupt pulse");
    AST_SLEEP_WAKE_RESET: assert property (
        s_sleep_wake |=> !reset_out_n && main_regulator_on)
        else $error("Sleep wake skipped reset or regulator");
    AST_EXCLUSIVE_WAKE: assert property (
        !(cyclic_on && cfg_q.timed_wake_enable))
        else $error("Cyclic sense and timed wake both on");
    AST_HOLD_TIME: assert property (
        $past(state_q) == wake_reset_pkg::st_reset && state_q == wake_reset_pkg::st_nreq
        |-> $past(tmr_q) == CW'(RST_HOLD_CYC - 1))
        else $error("Reset hold time wrong");
    AST_NO_WD_IN_DEBUG: assert property (
        debug_mode || state_q == wake_reset_pkg::st_sleep |-> !wd_exp)
        else $error("Watchdog ran in sleep or debug");

endmodule

// >>> test/host_link_model.sv
// Host side of the register link: one write at a time.
// Assumes link_busy answers every accepted write.
`timescale 1ns/1ps
module host_link_model (
    // Link pins
    input wire logic link_clk,
    input wire logic link_busy,
    output logic link_wr,
    output wake_reset_pkg::spi_write_t link_data
);
    // Idle link
    initial
    begin
        link_wr = 1'b0;
        link_data = '0;
    end
    // Waits out busy, so no request is ever refused
    task automatic wr(input logic [2:0] a, input logic [3:0] d);
        int i;
        i = 0;
        @(posedge link_clk);
        while (link_busy !== 1'b0 && i < 30)
        begin
            @(posedge link_clk);
            i++;
        end
        link_wr <= 1'b1;
        link_data <= {a, d};
        @(posedge link_clk);
        link_wr <= 1'b0;
        // Released word must not look valid
        link_data <= {~a, ~d};
        repeat (2) @(posedge link_clk);
        i = 0;
        while (link_busy !== 1'b0 && i < 30)
        begin
            @(posedge link_clk);
            i++;
        end
    endtask
endmodule

// >>> test/sbc_reset_watchdog_wakeup_bench.sv
// Bench for reset, watchdog and wake-up control.
// Assumes shortened counts; host writes go through the link model.
`timescale 1ns/1ps
module sbc_reset_watchdog_wakeup_bench;
    // Shortened counts
    localparam int HOLD = 20;
    localparam int NREQ = 200;
    localparam int WD = 100;
    localparam int FWAKE = 50;
    // Pins
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic main_reg_low = 1'b0;
    logic bus_activity = 1'b0;
    logic chip_select_n = 1'b1;
    logic debug_mode = 1'b0;
    logic [3:0] wake_inputs = 4'h3;
    logic link_wr, link_busy, reset_out_n, watchdog_fault_out_n;
    logic main_regulator_on, high_side_supply_switch, host_irq;
    wake_reset_pkg::spi_write_t link_data;
    wake_reset_pkg::wake_src_t wake_src;
    logic [3:0] wake_inputs_state;
    wake_reset_pkg::cfg_t cfg_state;
    wake_reset_pkg::state_t sbc_state;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    logic safe = 1'b0;
    // Clocks, phases unrelated
    always #2.5 clock = ~clock;
    always #6 link_clk = ~link_clk;
    sbc_reset_watchdog_wakeup #(.RST_HOLD_CYC(HOLD), .NREQ_CYC(NREQ), .WD_CYC(WD),
        .FWAKE_CYC(FWAKE), .CYC_PERIOD_CYC(40), .CYC_ON_CYC(8)) uut (
        .clock(clock), .arst_n(arst_n), .link_clk(link_clk), .link_wr(link_wr),
        .link_data(link_data), .link_busy(link_busy), .main_reg_low(main_reg_low),
        .bus_activity(bus_activity), .chip_select_n(chip_select_n),
        .wake_inputs(wake_inputs), .debug_mode(debug_mode), .reset_out_n(reset_out_n),
        .watchdog_fault_out_n(watchdog_fault_out_n), .main_regulator_on(main_regulator_on),
        .high_side_supply_switch(high_side_supply_switch), .host_irq(host_irq),
        .wake_src(wake_src), .wake_inputs_state(wake_inputs_state),
        .cfg_state(cfg_state), .sbc_state(sbc_state));
    host_link_model host (.link_clk(link_clk), .link_busy(link_busy),
        .link_wr(link_wr), .link_data(link_data));
    // Verdict
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Sample just after an edge, once it has settled
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic ws(input wake_reset_pkg::state_t s, input int lim);
        int i;
        i = 0;
        while (sbc_state !== s && i < lim)
        begin
            tick(1);
            i++;
        end
        chk(8'(sbc_state), 8'(s));
    endtask
    task automatic svc;
        host.wr(wake_reset_pkg::ADDR_TIM, 4'h0);
    endtask
    task automatic md(input logic [2:0] c);
        host.wr(wake_reset_pkg::ADDR_MODE, {safe, c});
    endtask
    // Power-up, unconfigured restart, first service
    task automatic t_power;
        chk(8'(reset_out_n), 8'h0);
        chk(8'(cfg_state.safe), 8'h0);
        ws(wake_reset_pkg::st_nreq, HOLD + 20);
        chk(8'(reset_out_n), 8'h1);
        ws(wake_reset_pkg::st_reset, NREQ + 20);
        ws(wake_reset_pkg::st_nreq, HOLD + 20);
        svc;
        ws(wake_reset_pkg::st_normal, 20);
        chk(8'(watchdog_fault_out_n), 8'h1);
        $display("test power done");
    endtask
    // Policy 1: timeout and undervoltage both reset
    task automatic t_pol1;
        ws(wake_reset_pkg::st_reset, WD + 20);
        chk(8'(reset_out_n), 8'h0);
        chk(8'(watchdog_fault_out_n), 8'h0);
        ws(wake_reset_pkg::st_nreq, HOLD + 20);
        chk(8'(watchdog_fault_out_n), 8'h0);
        svc;
        ws(wake_reset_pkg::st_normal, 20);
        chk(8'(watchdog_fault_out_n), 8'h1);
        @(posedge clock) main_reg_low <= 1'b1;
        tick(6);
        chk(8'(reset_out_n), 8'h0);
        @(posedge clock) main_reg_low <= 1'b0;
        ws(wake_reset_pkg::st_nreq, HOLD + 30);
        svc;
        ws(wake_reset_pkg::st_normal, 20);
        $display("test policy 1 done");
    endtask
    // Policy 2: timeout drops only the fault output
    task automatic t_pol2;
        safe = 1'b1;
        md(3'h0);
        chk(8'(cfg_state.safe), 8'h1);
        tick(WD + 20);
        chk(8'(watchdog_fault_out_n), 8'h0);
        chk(8'(reset_out_n), 8'h1);
        svc;
        chk(8'(watchdog_fault_out_n), 8'h1);
        $display("test policy 2 done");
    endtask
    // Sleep: timed wake, window expiry, chip-select wake
    task automatic t_sleep;
        svc;
        host.wr(wake_reset_pkg::ADDR_LP, 4'h2);
        host.wr(wake_reset_pkg::ADDR_WAKE, 4'h2);
        md(wake_reset_pkg::CMD_SLEEP);
        ws(wake_reset_pkg::st_sleep, 20);
        chk(8'(main_regulator_on), 8'h0);
        chk(8'(reset_out_n), 8'h0);
        ws(wake_reset_pkg::st_reset, FWAKE + 20);
        chk(8'(main_regulator_on), 8'h1);
        ws(wake_reset_pkg::st_nreq, HOLD + 20);
        ws(wake_reset_pkg::st_sleep, NREQ + 20);
        @(posedge clock) chip_select_n <= 1'b0;
        tick(3);
        @(posedge clock) chip_select_n <= 1'b1;
        ws(wake_reset_pkg::st_reset, 20);
        ws(wake_reset_pkg::st_nreq, HOLD + 20);
        svc;
        ws(wake_reset_pkg::st_normal, 20);
        chk(8'(cfg_state.safe), 8'h1);
        $display("test sleep done");
    endtask
    // Stop: bus wake off, input wake by pair level
    task automatic t_stop;
        chk(8'(wake_inputs_state), 8'h3);
        host.wr(wake_reset_pkg::ADDR_LP, 4'hb);
        chk(8'(cfg_state.timed_wake_enable), 8'h0);
        chk(8'(cfg_state.switch_auto_cycle), 8'h1);
        svc;
        host.wr(wake_reset_pkg::ADDR_LP, 4'h0);
        host.wr(wake_reset_pkg::ADDR_WAKE, 4'h2);
        md(wake_reset_pkg::CMD_STOP);
        ws(wake_reset_pkg::st_stop, 20);
        @(posedge clock) bus_activity <= 1'b1;
        tick(10);
        chk(8'(sbc_state), 8'(wake_reset_pkg::st_stop));
        @(posedge clock) bus_activity <= 1'b0;
        wake_inputs <= 4'hb;
        ws(wake_reset_pkg::st_nreq, 20);
        chk(8'(host_irq), 8'h1);
        chk(8'(wake_src.inputs), 8'h8);
        svc;
        ws(wake_reset_pkg::st_normal, 20);
        $display("test stop done");
    endtask
    // Stop with cyclic sense, then bus wake from stop
    task automatic t_cyc;
        int i = 0;
        svc;
        host.wr(wake_reset_pkg::ADDR_WAKE, 4'h2);
        host.wr(wake_reset_pkg::ADDR_LP, 4'h9);
        md(wake_reset_pkg::CMD_STOP);
        ws(wake_reset_pkg::st_stop, 20);
        while (high_side_supply_switch !== 1'b1 && i < 60)
        begin
            tick(1);
            i++;
        end
        chk(8'(high_side_supply_switch), 8'h1);
        @(posedge clock) wake_inputs <= 4'h9;
        ws(wake_reset_pkg::st_nreq, 60);
        chk(8'(wake_src.inputs), 8'h2);
        chk(8'(high_side_supply_switch), 8'h0);
        svc;
        host.wr(wake_reset_pkg::ADDR_BUS, 4'h1);
        md(wake_reset_pkg::CMD_STOP);
        @(posedge clock) bus_activity <= 1'b1;
        ws(wake_reset_pkg::st_nreq, 20);
        chk(8'(wake_src.bus), 8'h1);
        $display("test cyclic and bus done");
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        tick(1);
        t_power;
        t_pol1;
        t_pol2;
        t_sleep;
        t_stop;
        t_cyc;
        report_and_stop;
    end
endmodule
